// ---- logic/ebt_pkg.sv ----
// shared constants and types for the extend, table-branch and test unit
package ebt_pkg;
  localparam int          EBT_XLEN        = 32;
  localparam logic [3:0]  EBT_REG_SP      = 4'hD;
  localparam logic [3:0]  EBT_REG_PC      = 4'hF;
  // narrow sign-extend halfword opcode, bits 15:6
  localparam logic [9:0]  EBT_SXTH16_OP   = 10'h2C8;
  // wide sign-extend halfword first halfword
  localparam logic [15:0] EBT_SXTH32_HW1  = 16'hFA0F;
  // table branch first halfword, bits 15:4
  localparam logic [11:0] EBT_TB_HW1      = 12'hE8D;
  // table branch second halfword bits 15:5
  localparam logic [10:0] EBT_TB_HW2      = 11'h780;
  localparam int          EBT_TB_H_BIT    = 4;
  // immediate test forms, first halfword bits 15:11 and 9:4
  localparam logic [4:0]  EBT_TIMM_TOP    = 5'h1E;
  localparam logic [5:0]  EBT_TEQI_OP     = 6'h09;
  localparam logic [5:0]  EBT_TSTI_OP     = 6'h01;
  // register equivalence test, first halfword bits 15:4
  localparam logic [11:0] EBT_TEQR_HW1    = 12'hEA9;
  localparam logic [3:0]  EBT_ONES_FIELD  = 4'hF;
  localparam logic [1:0]  EBT_SH_LSL      = 2'h0;
  localparam logic [1:0]  EBT_SH_LSR      = 2'h1;
  localparam logic [1:0]  EBT_SH_ASR      = 2'h2;
  localparam logic [1:0]  EBT_SH_ROR      = 2'h3;
  localparam logic [31:0] EBT_PC_RESET    = 32'h0000_0000;
  localparam logic [3:0]  EBT_FLAGS_RESET = 4'h0;
  typedef enum logic [2:0] {
    EBT_OP_NONE, EBT_OP_SIGN_EXTEND_HALFWORD, EBT_OP_TBB, EBT_OP_TBH,
    EBT_OP_TEQ, EBT_OP_TST
  } ebt_op_t;
  typedef enum {EBT_ST_IDLE, EBT_ST_MEM} ebt_state_t;
endpackage : ebt_pkg

// ---- logic/ebt_shifter.sv ----
// barrel shifter with carry-out for shift decoder results
`timescale 1ns/1ps
`default_nettype none
module ebt_shifter
  import ebt_pkg::*;
(
  input  wire logic [31:0] value_in,
  input  wire logic [1:0]  shift_type,
  input  wire logic [4:0]  shift_imm,
  input  wire logic        carry_in,
  output logic      [31:0] value_out,
  output logic             carry_out
);
  logic [5:0]  amount;
  logic [63:0] wide;
  // decode immediate shift: zero means 32 for lsr/asr, rrx for ror
  always_comb begin
    amount    = {1'b0, shift_imm};
    value_out = value_in;
    carry_out = carry_in;
    wide      = 64'h0;
    case (shift_type)
      EBT_SH_LSL: begin
        if (shift_imm != 5'h0) begin
          wide      = {32'h0, value_in} << amount;
          value_out = wide[31:0];
          carry_out = wide[32];
        end
      end
      EBT_SH_LSR: begin
        if (shift_imm == 5'h0) amount = 6'h20;
        wide      = {value_in, 32'h0} >> amount;
        value_out = wide[63:32];
        carry_out = wide[31];
      end
      EBT_SH_ASR: begin
        if (shift_imm == 5'h0) amount = 6'h20;
        wide      = $signed({value_in, 32'h0}) >>> amount;
        value_out = wide[63:32];
        carry_out = wide[31];
      end
      default: begin
        if (shift_imm == 5'h0) begin
          value_out = {carry_in, value_in[31:1]};
          carry_out = value_in[0];
        end else begin
          wide      = {value_in, value_in} >> amount;
          value_out = wide[31:0];
          carry_out = wide[31];
        end
      end
    endcase
  end
endmodule : ebt_shifter
`default_nettype wire

// ---- logic/ebt_imm_expand.sv ----
// modified immediate expander with carry-out
`timescale 1ns/1ps
`default_nettype none
module ebt_imm_expand
  import ebt_pkg::*;
(
  input  wire logic [11:0] imm12,
  input  wire logic        carry_in,
  output logic      [31:0] imm32,
  output logic             carry_out
);
  logic [7:0]  b;
  logic [63:0] rot;
  // replicate patterns or rotate 1:imm7 right by imm12[11:7]
  always_comb begin
    b         = imm12[7:0];
    carry_out = carry_in;
    rot       = 64'h0;
    if (imm12[11:10] == 2'h0) begin
      case (imm12[9:8])
        2'h0:    imm32 = {24'h0, b};
        2'h1:    imm32 = {8'h0, b, 8'h0, b};
        2'h2:    imm32 = {b, 8'h0, b, 8'h0};
        default: imm32 = {b, b, b, b};
      endcase
    end else begin
      rot       = {2{24'h0, 1'b1, b[6:0]}} >> imm12[11:7];
      imm32     = rot[31:0];
      carry_out = rot[31];
    end
  end
endmodule : ebt_imm_expand
`default_nettype wire

// ---- logic/ebt_exec.sv ----
// decode and execute of sign-extend halfword, table branch and test ops
`timescale 1ns/1ps
`default_nettype none
module ebt_exec
  import ebt_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        INSTR_VALID,
  input  wire logic [31:0] INSTR,
  input  wire logic        INSTR_WIDE,
  input  wire logic [31:0] INSTR_PC,
  input  wire logic        COND_PASS,
  input  wire logic        IN_COND_BLOCK,
  input  wire logic        LAST_IN_BLOCK,
  input  wire logic [31:0] FIRST_REG_VALUE,
  input  wire logic [31:0] SECOND_REG_VALUE,
  input  wire logic        MEM_READY,
  input  wire logic [31:0] MEM_RDATA,
  input  wire logic        MEM_ERROR,
  output logic             INSTR_READY,
  output logic      [3:0]  FIRST_REG_FIELD,
  output logic      [3:0]  SECOND_REG_FIELD,
  output logic             REG_WE,
  output logic      [3:0]  REG_WADDR,
  output logic      [31:0] REG_WDATA,
  output logic             MEM_REQ,
  output logic      [31:0] MEM_ADDR,
  output logic             MEM_HALF,
  output logic             PC_WE,
  output logic      [31:0] PC_WDATA,
  output logic      [3:0]  CONDITION_FLAGS,
  output logic             UNPREDICTABLE,
  output logic             MEM_FAULT
);
  // register-number screen used by several encodings
  function automatic logic bad_reg(input logic [3:0] r);
    bad_reg = (r == EBT_REG_SP) || (r == EBT_REG_PC);
  endfunction : bad_reg

  ebt_state_t  state_reg;
  ebt_op_t     op;
  logic [15:0] hw1;
  logic [15:0] hw2;
  logic [3:0]  rn_sel;
  logic [3:0]  rm_sel;
  logic [3:0]  rd_sel;
  logic [1:0]  rot_sel;
  logic        unpred;
  logic [31:0] rotated;
  logic [31:0] sext_val;
  logic [31:0] shifted;
  logic        sh_carry;
  logic [31:0] imm32;
  logic        imm_carry;
  logic [31:0] test_res;
  logic        test_carry;
  logic [31:0] base_val;
  logic [31:0] tb_addr;
  logic [31:0] pc_base_reg;
  logic        half_reg;
  logic        accept;
  logic [15:0] entry;

  assign hw1 = INSTR_WIDE ? INSTR[31:16] : INSTR[15:0];
  assign hw2 = INSTR[15:0];

  // decode opcode and register fields
  always_comb begin
    op      = EBT_OP_NONE;
    rn_sel  = hw1[3:0];
    rm_sel  = hw2[3:0];
    rd_sel  = hw2[11:8];
    rot_sel = 2'h0;
    unpred  = 1'b0;
    if (!INSTR_WIDE) begin
      if (hw1[15:6] == EBT_SXTH16_OP) begin
        op     = EBT_OP_SIGN_EXTEND_HALFWORD;
        rm_sel = {1'b0, hw1[5:3]};
        rd_sel = {1'b0, hw1[2:0]};
      end
    end else if (hw1 == EBT_SXTH32_HW1 && hw2[15:12] == EBT_ONES_FIELD
                 && hw2[7] == 1'b1) begin
      op      = EBT_OP_SIGN_EXTEND_HALFWORD;
      rot_sel = hw2[5:4];
      unpred  = bad_reg(rd_sel) || bad_reg(rm_sel);
    end else if (hw1[15:4] == EBT_TB_HW1 && hw2[15:5] == EBT_TB_HW2) begin
      op     = hw2[EBT_TB_H_BIT] ? EBT_OP_TBH : EBT_OP_TBB;
      unpred = (rn_sel == EBT_REG_SP) || bad_reg(rm_sel)
               || (IN_COND_BLOCK && !LAST_IN_BLOCK);
    end else if (hw1[15:11] == EBT_TIMM_TOP && hw1[9:4] == EBT_TEQI_OP
                 && hw2[15] == 1'b0 && hw2[11:8] == EBT_ONES_FIELD) begin
      op     = EBT_OP_TEQ;
      rm_sel = 4'h0;
      unpred = bad_reg(rn_sel);
    end else if (hw1[15:11] == EBT_TIMM_TOP && hw1[9:4] == EBT_TSTI_OP
                 && hw2[15] == 1'b0 && hw2[11:8] == EBT_ONES_FIELD) begin
      op     = EBT_OP_TST;
      rm_sel = 4'h0;
      unpred = bad_reg(rn_sel);
    end else if (hw1[15:4] == EBT_TEQR_HW1
                 && hw2[11:8] == EBT_ONES_FIELD) begin
      op     = EBT_OP_TEQ;
      unpred = bad_reg(rn_sel) || bad_reg(rm_sel);
    end
  end

  // rotate by 0/8/16/24 then sign-extend the low halfword
  assign rotated  = (SECOND_REG_VALUE >> {rot_sel, 3'h0})
                  | (SECOND_REG_VALUE << (6'h20 - {1'b0, rot_sel, 3'h0}));
  assign sext_val = {{16{rotated[15]}}, rotated[15:0]};

  ebt_shifter u_shift (
    .value_in  (SECOND_REG_VALUE),
    .shift_type(hw2[5:4]),
    .shift_imm ({hw2[14:12], hw2[7:6]}),
    .carry_in  (CONDITION_FLAGS[1]),
    .value_out (shifted),
    .carry_out (sh_carry)
  );

  ebt_imm_expand u_imm (
    .imm12    ({hw1[10], hw2[14:12], hw2[7:0]}),
    .carry_in (CONDITION_FLAGS[1]),
    .imm32    (imm32),
    .carry_out(imm_carry)
  );

  // test result: xor for equivalence, and for the and-test
  always_comb begin
    test_carry = hw1[9] ? sh_carry : imm_carry;
    test_res   = 32'h0;
    if (op == EBT_OP_TEQ) begin
      test_res = FIRST_REG_VALUE ^ (hw1[9] ? shifted : imm32);
    end else if (op == EBT_OP_TST) begin
      test_res = FIRST_REG_VALUE & imm32;
    end
  end

  // pc reads as instruction address plus 4, which is the table start
  assign base_val = (rn_sel == EBT_REG_PC) ? INSTR_PC + 32'h4
                                           : FIRST_REG_VALUE;
  assign tb_addr  = (op == EBT_OP_TBH) ? base_val + {SECOND_REG_VALUE[30:0], 1'b0}
                                       : base_val + SECOND_REG_VALUE;
  assign accept   = INSTR_VALID && INSTR_READY && op != EBT_OP_NONE;
  assign entry    = half_reg ? MEM_RDATA[15:0] : {8'h0, MEM_RDATA[7:0]};

  // register source selection toward the register file
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      FIRST_REG_FIELD  <= 4'h0;
      SECOND_REG_FIELD <= 4'h0;
    end else begin
      FIRST_REG_FIELD  <= rn_sel;
      SECOND_REG_FIELD <= rm_sel;
    end
  end

  // sequencing: table branches wait for the memory read
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state_reg   <= EBT_ST_IDLE;
      INSTR_READY <= 1'b0;
      MEM_REQ     <= 1'b0;
      MEM_ADDR    <= 32'h0;
      MEM_HALF    <= 1'b0;
      half_reg    <= 1'b0;
      pc_base_reg <= EBT_PC_RESET;
    end else begin
      case (state_reg)
        EBT_ST_IDLE: begin
          INSTR_READY <= 1'b1;
          if (accept && COND_PASS && !unpred
              && (op == EBT_OP_TBB || op == EBT_OP_TBH)) begin
            state_reg   <= EBT_ST_MEM;
            INSTR_READY <= 1'b0;
            MEM_REQ     <= 1'b1;
            MEM_ADDR    <= tb_addr;
            MEM_HALF    <= (op == EBT_OP_TBH);
            half_reg    <= (op == EBT_OP_TBH);
            pc_base_reg <= INSTR_PC + 32'h4;
          end
        end
        EBT_ST_MEM: begin
          if (MEM_READY) begin
            MEM_REQ     <= 1'b0;
            state_reg   <= EBT_ST_IDLE;
            INSTR_READY <= 1'b1;
          end
        end
        default: state_reg <= EBT_ST_IDLE;
      endcase
    end
  end

  // result write-back, branch target and flag update
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      REG_WE          <= 1'b0;
      REG_WADDR       <= 4'h0;
      REG_WDATA       <= 32'h0;
      PC_WE           <= 1'b0;
      PC_WDATA        <= EBT_PC_RESET;
      CONDITION_FLAGS <= EBT_FLAGS_RESET;
      UNPREDICTABLE   <= 1'b0;
      MEM_FAULT       <= 1'b0;
    end else begin
      REG_WE        <= 1'b0;
      PC_WE         <= 1'b0;
      UNPREDICTABLE <= accept && COND_PASS && unpred;
      MEM_FAULT     <= 1'b0;
      if (accept && COND_PASS && !unpred) begin
        if (op == EBT_OP_SIGN_EXTEND_HALFWORD) begin
          REG_WE    <= 1'b1;
          REG_WADDR <= rd_sel;
          REG_WDATA <= sext_val;
        end else if (op == EBT_OP_TEQ || op == EBT_OP_TST) begin
          CONDITION_FLAGS <= {test_res[31], test_res == 32'h0,
                              test_carry, CONDITION_FLAGS[0]};
        end
      end
      if (state_reg == EBT_ST_MEM && MEM_READY) begin
        if (MEM_ERROR) begin
          MEM_FAULT <= 1'b1;
        end else begin
          PC_WE    <= 1'b1;
          PC_WDATA <= pc_base_reg + {15'h0, entry, 1'b0};
        end
      end
    end
  end

  // checks on write-back, flags and the table read sequence
  property p_tst_no_write;
    @(posedge CLOCK) disable iff (RESET)
    accept && op == EBT_OP_TST |=> !REG_WE;
  endproperty
  a_tst_no_write: assert property (p_tst_no_write)
    else $error("and-test wrote a register");
  property p_flags_v;
    @(posedge CLOCK) disable iff (RESET)
    accept && (op == EBT_OP_TEQ || op == EBT_OP_TST)
    |=> CONDITION_FLAGS[0] == $past(CONDITION_FLAGS[0]);
  endproperty
  a_flags_v: assert property (p_flags_v)
    else $error("overflow flag changed by a test");
  property p_cond_fail;
    @(posedge CLOCK) disable iff (RESET)
    accept && !COND_PASS |=> !REG_WE && $stable(CONDITION_FLAGS);
  endproperty
  a_cond_fail: assert property (p_cond_fail)
    else $error("failed condition had an effect");
  property p_unpred;
    @(posedge CLOCK) disable iff (RESET)
    accept && COND_PASS && unpred |=> UNPREDICTABLE && !REG_WE;
  endproperty
  a_unpred: assert property (p_unpred)
    else $error("unpredictable encoding not flagged");
  property p_sign_extend_halfword;
    @(posedge CLOCK) disable iff (RESET)
    accept && COND_PASS && !unpred && op == EBT_OP_SIGN_EXTEND_HALFWORD
    |=> REG_WE && REG_WDATA[31:16] == {16{REG_WDATA[15]}};
  endproperty
  a_sign_extend_halfword: assert property (p_sign_extend_halfword)
    else $error("sign extension wrong");
  property p_tb_req;
    @(posedge CLOCK) disable iff (RESET)
    accept && COND_PASS && !unpred && op == EBT_OP_TBH
    |=> MEM_REQ && MEM_HALF;
  endproperty
  a_tb_req: assert property (p_tb_req)
    else $error("halfword table read missing");
  property p_tb_pc;
    @(posedge CLOCK) disable iff (RESET)
    state_reg == EBT_ST_MEM && MEM_READY && !MEM_ERROR
    |=> PC_WE && PC_WDATA[0] == 1'b0;
  endproperty
  a_tb_pc: assert property (p_tb_pc)
    else $error("table branch pc not written");
  property p_tb_nomem;
    @(posedge CLOCK) disable iff (RESET)
    accept && !COND_PASS && state_reg == EBT_ST_IDLE |=> !MEM_REQ;
  endproperty
  a_tb_nomem: assert property (p_tb_nomem)
    else $error("memory read on failed condition");
  c_sign_extend_halfword: cover property (@(posedge CLOCK) accept && op == EBT_OP_SIGN_EXTEND_HALFWORD);
  c_tbb: cover property (@(posedge CLOCK) PC_WE && !MEM_HALF);
  c_tbh: cover property (@(posedge CLOCK) PC_WE && MEM_HALF);
  c_teq: cover property (@(posedge CLOCK) accept && op == EBT_OP_TEQ);
endmodule : ebt_exec
`default_nettype wire

// ---- verif/ebt_mem_model.sv ----
// data memory stand-in that answers table reads after a set delay
`timescale 1ns/1ps
`default_nettype none
module ebt_mem_model (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        MEM_REQ,
  input  wire logic [31:0] MEM_ADDR,
  input  wire logic        MEM_HALF,
  input  wire logic [3:0]  DELAY,
  input  wire logic        ERR_EN,
  output logic             MEM_READY,
  output logic      [31:0] MEM_RDATA,
  output logic             MEM_ERROR
);
  logic [3:0] cnt_reg;
  logic       hold_reg;

  // table contents are a fixed scramble of the byte address
  function automatic logic [7:0] tab_byte(input logic [31:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : tab_byte

  // one answer per request; read data toggles whenever nothing is returned
  always_ff @(posedge CLOCK) begin
    MEM_RDATA <= ~MEM_RDATA;
    if (RESET) begin
      MEM_READY <= 1'b0;
      MEM_ERROR <= 1'b0;
      cnt_reg   <= 4'h0;
      hold_reg  <= 1'b0;
      MEM_RDATA <= 32'h5A5A_5A5A;
    end else if (MEM_READY) begin
      MEM_READY <= 1'b0;
      MEM_ERROR <= 1'b0;
      hold_reg  <= 1'b1; // request drops on the edge that sees ready
    end else if (hold_reg) begin
      hold_reg <= 1'b0;
    end else if (MEM_REQ && cnt_reg == DELAY) begin
      MEM_READY <= 1'b1;
      MEM_ERROR <= ERR_EN;
      cnt_reg   <= 4'h0;
      MEM_RDATA <= MEM_HALF ? {16'hC3C3, tab_byte(MEM_ADDR + 32'h1),
                   tab_byte(MEM_ADDR)} : {24'hC3C3C3, tab_byte(MEM_ADDR)};
    end else if (MEM_REQ) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : ebt_mem_model
`default_nettype wire

// ---- verif/tb_extend_branch_test_exec.sv ----
// self-checking bench for the extend, table-branch and test unit
`timescale 1ns/1ps
`default_nettype none
module tb_extend_branch_test_exec
  import ebt_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst, valid, wide, cpass, in_blk, last_blk, err_en;
  logic [31:0] instr, pc, v1, v2, s_wdata, s_pwdata, s_maddr;
  logic [3:0]  dly, s_waddr;
  logic        rdy, we, pwe, mreq, mhalf, unp, mflt, mrdy, merr;
  logic [3:0]  waddr, flags, f1, f2;
  logic [31:0] wdata, pwdata, maddr, mrdata;
  logic        s_we, s_pwe, s_unp, s_flt, s_req, s_half;
  int          err_count = 0;
  int          checked = 0;

  ebt_exec i_dut (
    .CLOCK(clk), .RESET(rst), .INSTR_VALID(valid), .INSTR(instr),
    .INSTR_WIDE(wide), .INSTR_PC(pc), .COND_PASS(cpass),
    .IN_COND_BLOCK(in_blk), .LAST_IN_BLOCK(last_blk),
    .FIRST_REG_VALUE(v1), .SECOND_REG_VALUE(v2), .MEM_READY(mrdy),
    .MEM_RDATA(mrdata), .MEM_ERROR(merr), .INSTR_READY(rdy),
    .FIRST_REG_FIELD(f1), .SECOND_REG_FIELD(f2), .REG_WE(we),
    .REG_WADDR(waddr), .REG_WDATA(wdata), .MEM_REQ(mreq),
    .MEM_ADDR(maddr), .MEM_HALF(mhalf), .PC_WE(pwe), .PC_WDATA(pwdata),
    .CONDITION_FLAGS(flags), .UNPREDICTABLE(unp), .MEM_FAULT(mflt));
  ebt_mem_model i_mem (
    .CLOCK(clk), .RESET(rst), .MEM_REQ(mreq), .MEM_ADDR(maddr),
    .MEM_HALF(mhalf), .DELAY(dly), .ERR_EN(err_en), .MEM_READY(mrdy),
    .MEM_RDATA(mrdata), .MEM_ERROR(merr));

  // core clock, 10 ns period
  always #5 clk = ~clk;

  function automatic logic [7:0] tab_byte(input logic [31:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : tab_byte

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // offer one instruction at a falling edge and record what comes back
  task automatic run_op(input logic [31:0] i, input logic w,
                        input logic [31:0] a, input logic [31:0] b);
    int n;
    instr = i;
    wide  = w;
    v1    = a;
    v2    = b;
    valid = 1'b1;
    n     = 0;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    check(32'(n < 20), 32'h1);
    {s_we, s_pwe, s_unp, s_flt, s_req} = 5'h00;
    for (n = 0; n < 10; n++) begin
      @(negedge clk);
      if (n == 0) valid = 1'b0;
      if (we === 1'b1) {s_we, s_waddr, s_wdata} = {1'b1, waddr, wdata};
      if (pwe === 1'b1) {s_pwe, s_pwdata} = {1'b1, pwdata};
      if (mreq === 1'b1) {s_req, s_maddr, s_half} = {1'b1, maddr, mhalf};
      if (unp === 1'b1) s_unp = 1'b1;
      if (mflt === 1'b1) s_flt = 1'b1;
    end
  endtask : run_op

  task automatic t_sign_extend_halfword;
    logic [31:0] r;
    run_op({16'h0, EBT_SXTH16_OP, 3'h2, 3'h5}, 1'b0, 32'h0, 32'h1234_8001);
    check(s_waddr, 32'h5);
    check(f2, 32'h2);
    check(s_wdata, 32'hFFFF_8001);
    for (int k = 0; k < 4; k++) begin
      r = (32'h80FF_0102 >> (8 * k)) | (32'h80FF_0102 << (32 - 8 * k));
      run_op({EBT_SXTH32_HW1, 4'hF, 4'h3, 2'h2, 2'(k), 4'h7}, 1'b1,
             32'h0, 32'h80FF_0102);
      check(s_waddr, 32'h3);
      check(s_wdata, {{16{r[15]}}, r[15:0]});
    end
    run_op({EBT_SXTH32_HW1, 4'hF, 4'hD, 2'h2, 2'h0, 4'h7}, 1'b1, 0, 0);
    check({s_unp, s_we}, 32'h2);
    run_op({EBT_SXTH32_HW1, 4'hF, 4'h3, 2'h2, 2'h0, 4'hF}, 1'b1, 0, 0);
    check({s_unp, s_we}, 32'h2);
    cpass = 1'b0;
    run_op({16'h0, EBT_SXTH16_OP, 3'h2, 3'h5}, 1'b0, 32'h0, 32'h1);
    check({s_unp, s_we}, 32'h0);
    cpass = 1'b1;
    $display("test sign_extend_halfword done");
  endtask : t_sign_extend_halfword

  task automatic t_table;
    logic [31:0] adr, val, base;
    for (int k = 0; k < 5; k++) begin
      dly  = (k > 1) ? 4'h3 : 4'h0;
      base = (k == 4) ? pc + 32'h4 : 32'h1000;
      adr  = base + (32'(k) + 32'h3 << k[0]);
      val = k[0] ? {16'h0, tab_byte(adr + 32'h1), tab_byte(adr)}
                 : {24'h0, tab_byte(adr)};
      run_op({EBT_TB_HW1, (k == 4) ? 4'hF : 4'h2, EBT_TB_HW2, k[0], 4'h6},
             1'b1, base, 32'(k) + 32'h3);
      check(s_maddr, adr);
      check(f1, (k == 4) ? 32'hF : 32'h2);
      check({s_req, s_half}, {31'h1, k[0]});
      check(s_pwdata, pc + 32'h4 + 2 * val);
      check(s_pwe, 32'h1);
    end
    for (int k = 0; k < 4; k++) begin
      in_blk = (k == 3);
      run_op({EBT_TB_HW1, (k == 0) ? 4'hD : 4'h2, EBT_TB_HW2, 1'b0,
              (k == 1) ? 4'hD : (k == 2) ? 4'hF : 4'h6}, 1'b1, 0, 0);
      check({s_unp, s_req}, 32'h2);
    end
    last_blk = 1'b1;
    run_op({EBT_TB_HW1, 4'h2, EBT_TB_HW2, 1'b0, 4'h6}, 1'b1, 0, 0);
    check({s_unp, s_req, s_pwe}, 32'h3);
    {in_blk, last_blk, cpass} = 3'h0;
    run_op({EBT_TB_HW1, 4'h2, EBT_TB_HW2, 1'b0, 4'h6}, 1'b1, 0, 0);
    check({s_unp, s_req, s_pwe}, 32'h0);
    {cpass, err_en} = 2'h3;
    run_op({EBT_TB_HW1, 4'h2, EBT_TB_HW2, 1'b0, 4'h6}, 1'b1, 0, 0);
    check({s_flt, s_pwe}, 32'h2);
    err_en = 1'b0;
    $display("test table done");
  endtask : t_table

  task automatic imm_case(input logic [5:0] op, input logic [11:0] im,
                          input logic [3:0] rn, input logic [31:0] a,
                          input logic [3:0] exp);
    run_op({EBT_TIMM_TOP, im[11], op, rn, 1'b0, im[10:8], 4'hF, im[7:0]},
           1'b1, a, 32'h0);
    check(flags, exp);
    check(s_we, 32'h0);
  endtask : imm_case

  task automatic reg_case(input logic [4:0] sh, input logic [1:0] ty,
                          input logic [3:0] rm, input logic [31:0] b,
                          input logic [3:0] exp);
    run_op({EBT_TEQR_HW1, 4'h1, 1'b0, sh[4:2], 4'hF, sh[1:0], ty, rm},
           1'b1, 32'h0000_000F * (b == 32'hF8), b);
    check(flags, exp);
  endtask : reg_case

  task automatic t_test;
    imm_case(EBT_TSTI_OP, 12'h0FF, 4'h4, 32'h8000_0100, 4'h4);
    imm_case(EBT_TEQI_OP, 12'h400, 4'h4, 32'h0, 4'hA);
    imm_case(EBT_TSTI_OP, 12'h400, 4'h4, 32'h7FFF_FFFF, 4'h6);
    imm_case(EBT_TEQI_OP, 12'h0FF, 4'h4, 32'h1FF, 4'h2);
    imm_case(EBT_TEQI_OP, 12'h400, 4'hD, 32'h0, 4'h2);
    check(s_unp, 32'h1);
    imm_case(EBT_TSTI_OP, 12'h400, 4'hF, 32'h0, 4'h2);
    reg_case(5'h00, EBT_SH_LSL, 4'h2, 32'h1, 4'h2);
    reg_case(5'h04, EBT_SH_LSR, 4'h2, 32'hF8, 4'h6);
    reg_case(5'h00, EBT_SH_ASR, 4'h2, 32'h8000_0000, 4'hA);
    reg_case(5'h00, EBT_SH_ROR, 4'h2, 32'h2, 4'h8);
    reg_case(5'h04, EBT_SH_ROR, 4'h2, 32'hF, 4'hA);
    reg_case(5'h00, EBT_SH_LSL, 4'hD, 32'h1, 4'hA);
    check(s_unp, 32'h1);
    cpass = 1'b0;
    reg_case(5'h00, EBT_SH_LSL, 4'h2, 32'h1, 4'hA);
    cpass = 1'b1;
    $display("test flags done");
  endtask : t_test

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // main sequence: reset for five cycles, then the scenarios
  initial begin
    {rst, valid, wide, in_blk, last_blk, err_en} = 6'h20;
    {instr, v1, v2, dly, cpass} = {96'h0, 4'h0, 1'b1};
    pc = 32'h0000_0200;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_sign_extend_halfword();
    t_table();
    t_test();
    finish_test();
  end

  // hang guard, well past the few hundred cycles the scenarios need
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule : tb_extend_branch_test_exec
`default_nettype wire
